/* dac_i2c_pkg.sv */
// Package: constants, types and register layout of the converter command port
package dac_i2c_pkg;
  localparam logic [4:0] ADDR_FIXED     = 5'h13;    // Upper five address bits 10011
  localparam logic [3:0] OP_NOP         = 4'h0;
  localparam logic [3:0] OP_LOAD_INPUT  = 4'h1;
  localparam logic [3:0] OP_TRANSFER    = 4'h2;
  localparam logic [3:0] OP_LOAD_BOTH   = 4'h3;
  localparam logic [3:0] OP_CONTROL     = 4'h4;
  localparam int         CTL_RESET_BIT  = 15;
  localparam int         CTL_PD_HI_BIT  = 14;
  localparam int         CTL_PD_LO_BIT  = 13;
  localparam int         CTL_REF_BIT    = 12;
  localparam int         CTL_GAIN_BIT   = 11;
  localparam logic [15:0] CODE_RESET    = 16'h0000;  // Zero scale
  localparam logic [3:0]  CTRL_RESET    = 4'h0;      // Normal mode, ref on, gain x1
  localparam logic [3:0]  BIT_LAST      = 4'h7;      // Index of last data bit in a byte
  localparam logic [1:0]  BYTE_LAST     = 2'h2;      // Index of low data byte

  // Control settings fields
  typedef struct packed {
    logic [1:0] powerdown_sel;  // 00 normal, 01 1k, 10 100k, 11 float
    logic       ref_disable;
    logic       gain;
  } control_s;

  // One decoded write, passed from link to system domain
  typedef struct packed {
    logic [3:0]  opcode;
    logic [15:0] data;
  } command_s;

  typedef enum logic [2:0] {
    LS_IDLE, LS_ADDR, LS_ADDR_ACK, LS_WR, LS_WR_ACK, LS_RD, LS_RD_ACK, LS_IGNORE
  } link_state_e;
endpackage

/* dac_i2c_port.sv */
// Two-wire target port, command decoder and converter registers
`timescale 1ns/10ps

// Behaviour
// - Serial clock up to 400 kHz handled; bench controller runs a 160 ns bit (6.25 MHz).
// - Only 7-bit addressing; ten-bit and general call never acknowledged.
// - Matching address acknowledged by pulling data low on ninth pulse.
// - Each byte is eight bits, MSB first, then one acknowledge bit.
// - Data changes only while clock low, except start and stop.
// - Address is 10011, address-select level, then zero.
// - Write is address, command, high byte, low byte, each acknowledged.
// - Upper command nibble selects nop, load, transfer, load both, control.
// - Converter code is the 16-bit left-justified data word.
// - Control write: bit15 reset, bits14-13 power-down, bit12 ref, bit11 gain.
// - Load-input only preloads; output takes it on strobe or transfer.
// - Any write to output register also copies into input register.
// - Transfer copies input to output, ignoring the data bytes.
// - Load-both writes output at write end and refreshes input.
// - Gain 0 gives one times reference, 1 gives twice.
// - Reference disable bit clear by default keeps reference on.
// - Power-down bits select normal, 1k, 100k or floating output.
// - Power-down keeps output code and still accepts writes.
// - Software reset restores defaults and then clears itself.
// - Load strobe falling edge transfers input to output, ignored during access.
// - Read returns two bytes of input register contents.
// - Reset pin low holds defaults, zero scale and ignores commands.
module dac_i2c_port
(
  input  wire logic        CLK,                 // System clock, 200 MHz
  input  wire logic        SYS_RST,             // Asynchronous reset, active high
  input  wire logic        SCL_CLK,             // Serial clock used as link clock
  input  wire logic        SDA_IN,              // Data line level
  output logic             SDA_OUT,             // Data line drive value, always 0
  output logic             SDA_OE_N,            // Low while pulling data line low
  input  wire logic        ADDRESS_SELECT_PIN,  // Address bit 1 select
  input  wire logic        LOAD_OUTPUT_STROBE_N, // Hardware load, falling edge acts
  input  wire logic        RESET_PIN_N,         // Hardware reset, active low
  output logic [15:0]      ACTIVE_OUTPUT_CODE,  // Code driving the converter
  output logic             GAIN_X2,             // Output span twice reference
  output logic             REF_DISABLE,         // Internal reference off
  output logic             POWERDOWN_SEL_HI,    // Power-down select high bit
  output logic             POWERDOWN_SEL_LO     // Power-down select low bit
);

  // ****************************************
  // Link domain state
  // ****************************************
  // Link state machine in one struct, registered on the rising serial clock
  typedef struct packed {
    dac_i2c_pkg::link_state_e   state;
    logic [2:0]                 bit_cnt;
    logic [7:0]                 shift;
    logic [1:0]                 byte_cnt;
    logic                       rd_mode;
    logic                       sda_oe_n;
    dac_i2c_pkg::command_s      cmd;
    logic                       cmd_toggle;
    logic                       busy;
    logic [15:0]                rd_word;
  } link_s;

  // All system state in one struct, registered on the system clock
  typedef struct packed {
    logic [15:0]           staging_code_reg;
    logic [15:0]           active_output_code_reg;
    dac_i2c_pkg::control_s control_settings_reg;
    logic [2:0]            tog_sync;
    logic [1:0]            busy_sync;
    logic [2:0]            strobe_sync;
    logic [1:0]            rst_sync;
    logic [15:0]           rd_snap;
    logic                  pending;
  } sys_s;

  link_s lk_reg;
  link_s lk_next;
  sys_s  sy_reg;
  sys_s  sy_next;

  // Start and stop detection, flip-flops clocked by the data line edges
  // These flops are clocked by the data line itself, so a start or stop is
  // caught even when no serial clock edge follows it. Each event flips a
  // toggle; the link domain compares it with its own copy to see a new event.
  logic start_tog;
  logic stop_tog;
  logic start_seen_reg;
  logic stop_seen_reg;
  logic [15:0] rd_word_link;

  // Start: data falls while clock high
  always_ff @(negedge SDA_IN or posedge SYS_RST)
  begin
    if (SYS_RST)
      start_tog <= 1'b0;
    else if (SCL_CLK)
      start_tog <= ~start_tog;
  end

  // Stop: data rises while clock high
  always_ff @(posedge SDA_IN or posedge SYS_RST)
  begin
    if (SYS_RST)
      stop_tog <= 1'b0;
    else if (SCL_CLK)
      stop_tog <= ~stop_tog;
  end

  // Start or stop events seen on the next serial clock edge
  // Copying the toggles here marks the event as consumed, so each start
  // or stop acts on exactly one rising serial clock edge
  logic start_ack_reg;
  logic stop_ack_reg;
  always_ff @(posedge SCL_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      start_ack_reg <= 1'b0;
      stop_ack_reg  <= 1'b0;
    end
    else
    begin
      start_ack_reg <= start_tog;
      stop_ack_reg  <= stop_tog;
    end
  end
  assign start_seen_reg = start_ack_reg ^ start_tog;
  assign stop_seen_reg  = stop_ack_reg ^ stop_tog;

  // Readback word is only sampled while stable (snapshot held in system domain)
  assign rd_word_link = sy_reg.rd_snap;

  // Busy as the system domain sees it: a start raises it and a stop drops it
  // at once, without waiting for a serial clock edge that an idle bus never
  // gives; the load strobe and the readback snapshot both key off it
  logic busy_link;
  assign busy_link = start_seen_reg | (lk_reg.busy & ~stop_seen_reg);

  // ****************************************
  // Address decode, shared by the receive and drive logic
  // ****************************************
  // True when the upper seven bits of a received byte name this device
  function automatic logic addr_match(input logic [7:0] rx, input logic sel);
    logic [6:0] own;
    begin
      own        = {dac_i2c_pkg::ADDR_FIXED, sel, 1'b0};
      addr_match = (rx[7:1] == own);
    end
  endfunction

  // ****************************************
  // Link receive and transmit, sampled on rising serial clock
  // ****************************************
  always_comb
  begin
    // Hold every field unless the bus event below changes it; a start always
    // wins over a stop that is still pending from the end of the last transfer
    lk_next = lk_reg;
    if (start_seen_reg)
    begin
      lk_next.state    = dac_i2c_pkg::LS_ADDR;
      lk_next.shift    = {7'h00, SDA_IN};
      lk_next.bit_cnt  = 3'h1;
      lk_next.byte_cnt = 2'h0;
      lk_next.busy     = 1'b1;
    end
    else if (stop_seen_reg)
    begin
      lk_next.state = dac_i2c_pkg::LS_IDLE;
      lk_next.busy  = 1'b0;
    end
    else
    begin
      case (lk_reg.state)
        dac_i2c_pkg::LS_ADDR, dac_i2c_pkg::LS_WR:
        begin
          lk_next.shift   = {lk_reg.shift[6:0], SDA_IN};  // MSB first
          lk_next.bit_cnt = lk_reg.bit_cnt + 3'h1;
          if (lk_reg.bit_cnt == dac_i2c_pkg::BIT_LAST[2:0])
            lk_next.state = (lk_reg.state == dac_i2c_pkg::LS_ADDR) ?
                            dac_i2c_pkg::LS_ADDR_ACK : dac_i2c_pkg::LS_WR_ACK;
        end
        dac_i2c_pkg::LS_ADDR_ACK:
        begin
          // Exact 7-bit match only; general call never matches
          // The direction bit picks read or write; both are acknowledged
          // The drive side pulled the line low for this same match
          if (addr_match(lk_reg.shift, ADDRESS_SELECT_PIN))
          begin
            lk_next.rd_mode = lk_reg.shift[0];
            lk_next.rd_word = rd_word_link;
            lk_next.state   = lk_reg.shift[0] ? dac_i2c_pkg::LS_RD : dac_i2c_pkg::LS_WR;
            lk_next.bit_cnt = 3'h0;
            lk_next.shift   = lk_reg.shift[0] ? rd_word_link[15:8] : 8'h00;
          end
          else
            lk_next.state = dac_i2c_pkg::LS_IGNORE;
        end
        dac_i2c_pkg::LS_WR_ACK:
        begin
          // Bytes 0,1,2 are command, high, low
          // The command is handed over at the low byte's acknowledge; the
          // toggle tells the system domain that a whole word stands ready
          case (lk_reg.byte_cnt)
            2'h0: lk_next.cmd.opcode = lk_reg.shift[7:4];
            2'h1: lk_next.cmd.data[15:8] = lk_reg.shift;
            default: lk_next.cmd.data[7:0] = lk_reg.shift;
          endcase
          if (lk_reg.byte_cnt == dac_i2c_pkg::BYTE_LAST)
          begin
            lk_next.cmd.data[7:0] = lk_reg.shift;
            lk_next.cmd_toggle    = ~lk_reg.cmd_toggle;
            lk_next.byte_cnt      = 2'h0;
          end
          else
            lk_next.byte_cnt = lk_reg.byte_cnt + 2'h1;
          lk_next.bit_cnt = 3'h0;
          lk_next.state   = dac_i2c_pkg::LS_WR;
        end
        dac_i2c_pkg::LS_RD:
        begin
          lk_next.bit_cnt = lk_reg.bit_cnt + 3'h1;
          if (lk_reg.bit_cnt == dac_i2c_pkg::BIT_LAST[2:0])
            lk_next.state = dac_i2c_pkg::LS_RD_ACK;
          else
            lk_next.shift = {lk_reg.shift[6:0], 1'b0};
        end
        dac_i2c_pkg::LS_RD_ACK:
        begin
          // Controller acknowledge low continues with the low byte
          // No acknowledge, or one after the low byte, ends the read
          if (!SDA_IN && lk_reg.byte_cnt == 2'h0)
          begin
            lk_next.byte_cnt = 2'h1;
            lk_next.shift    = lk_reg.rd_word[7:0];
            lk_next.bit_cnt  = 3'h0;
            lk_next.state    = dac_i2c_pkg::LS_RD;
          end
          else
            lk_next.state = dac_i2c_pkg::LS_IGNORE;
        end
        dac_i2c_pkg::LS_IDLE, dac_i2c_pkg::LS_IGNORE: lk_next.busy = lk_reg.busy;
        default: lk_next.state = dac_i2c_pkg::LS_IDLE;
      endcase
    end
  end

  always_ff @(posedge SCL_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      lk_reg <= '{state: dac_i2c_pkg::LS_IDLE, sda_oe_n: 1'b1, default: '0};
    else
      lk_reg <= lk_next;  // One step per edge, any rate up to fast mode
  end

  // ****************************************
  // Data line drive, changed on falling serial clock
  // ****************************************
  // Drive changes only on the falling serial clock edge, so the line is
  // settled well before the controller samples it on the next rising edge
  logic sda_oe_n_reg;
  logic sda_out_reg;
  always_ff @(negedge SCL_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      sda_oe_n_reg <= 1'b1;
      sda_out_reg  <= 1'b0;
    end
    else
    begin
      sda_out_reg  <= 1'b0;                                       // Open drain: low only
      sda_oe_n_reg <= 1'b1;
      if (lk_reg.state == dac_i2c_pkg::LS_ADDR_ACK &&
          addr_match(lk_reg.shift, ADDRESS_SELECT_PIN))
        sda_oe_n_reg <= 1'b0;
      else if (lk_reg.state == dac_i2c_pkg::LS_WR_ACK)
        sda_oe_n_reg <= 1'b0;
      else if (lk_reg.state == dac_i2c_pkg::LS_RD)
        sda_oe_n_reg <= lk_reg.shift[7];
    end
  end

  // ****************************************
  // System domain: crossings, decode and registers
  // ****************************************
  always_comb
  begin
    // Crossing rules for this domain: every single-bit signal from the link or a
    // pin passes two flip-flops first. The command word itself is not synced; it
    // is completed on the same serial clock edge that flips its toggle and then stands
    // for a whole bit time, far longer than the three system clocks the toggle
    // needs to arrive, so it is stable whenever it is read here.
    sy_next             = sy_reg;
    sy_next.tog_sync    = {sy_reg.tog_sync[1:0], lk_reg.cmd_toggle};
    sy_next.busy_sync   = {sy_reg.busy_sync[0], busy_link};
    sy_next.strobe_sync = {sy_reg.strobe_sync[1:0], LOAD_OUTPUT_STROBE_N};
    sy_next.rst_sync    = {sy_reg.rst_sync[0], RESET_PIN_N};
    // Snapshot follows staging while idle and freezes during an access, so the
    // link reads a word that cannot change under it
    sy_next.rd_snap     = sy_reg.busy_sync[1] ? sy_reg.rd_snap : sy_reg.staging_code_reg;
    if (!sy_reg.rst_sync[1])
    begin
      sy_next.staging_code_reg       = dac_i2c_pkg::CODE_RESET;
      sy_next.active_output_code_reg = dac_i2c_pkg::CODE_RESET;
      sy_next.control_settings_reg   = dac_i2c_pkg::CTRL_RESET;
    end
    else
    begin
      // Strobe falling edge outside an access moves staging to output
      if (sy_reg.strobe_sync[2] && !sy_reg.strobe_sync[1] && !sy_reg.busy_sync[1])
        sy_next.active_output_code_reg = sy_reg.staging_code_reg;
      // Toggle on the command word, stable since the edge that flipped the toggle
      // Codes above control fall to the default branch and change nothing
      if (sy_reg.tog_sync[2] != sy_reg.tog_sync[1])
      begin
        case (lk_reg.cmd.opcode)
          dac_i2c_pkg::OP_LOAD_INPUT:
            sy_next.staging_code_reg = lk_reg.cmd.data;
          dac_i2c_pkg::OP_TRANSFER:
            sy_next.active_output_code_reg = sy_reg.staging_code_reg;
          dac_i2c_pkg::OP_LOAD_BOTH:
          begin
            sy_next.active_output_code_reg = lk_reg.cmd.data;
            sy_next.staging_code_reg       = lk_reg.cmd.data;
          end
          dac_i2c_pkg::OP_CONTROL:
          begin
            if (lk_reg.cmd.data[dac_i2c_pkg::CTL_RESET_BIT])
            begin
              sy_next.staging_code_reg       = dac_i2c_pkg::CODE_RESET;
              sy_next.active_output_code_reg = dac_i2c_pkg::CODE_RESET;
              sy_next.control_settings_reg   = dac_i2c_pkg::CTRL_RESET;
            end
            else
              sy_next.control_settings_reg = {
                lk_reg.cmd.data[dac_i2c_pkg::CTL_PD_HI_BIT],
                lk_reg.cmd.data[dac_i2c_pkg::CTL_PD_LO_BIT],
                lk_reg.cmd.data[dac_i2c_pkg::CTL_REF_BIT],
                lk_reg.cmd.data[dac_i2c_pkg::CTL_GAIN_BIT]};
          end
          default: sy_next.pending = sy_reg.pending;
        endcase
      end
    end
  end

  // System register; the strobe history resets to the idle high level so that
  // no false falling edge is seen just after reset
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      sy_reg <= '{tog_sync: 3'h0, busy_sync: 2'h0, strobe_sync: 3'h7, rst_sync: 2'h0,
                  default: '0};
    else
      sy_reg <= sy_next;
  end

  // Outputs
  // Every output is a register bit; the data line drive value stays low and
  // only its enable moves, as an open-drain line needs
  assign SDA_OUT            = sda_out_reg;
  assign SDA_OE_N           = sda_oe_n_reg;
  assign ACTIVE_OUTPUT_CODE = sy_reg.active_output_code_reg;
  assign GAIN_X2            = sy_reg.control_settings_reg.gain;
  assign REF_DISABLE        = sy_reg.control_settings_reg.ref_disable;
  assign POWERDOWN_SEL_HI   = sy_reg.control_settings_reg.powerdown_sel[1];
  assign POWERDOWN_SEL_LO   = sy_reg.control_settings_reg.powerdown_sel[0];
endmodule

/* dac_i2c_checker.sv */
// Checker: properties on the command port pins
`timescale 1ns/10ps
// ****************
// Port checker
// ****************
module dac_i2c_checker
(
  input wire logic        CLK,                  // Clock
  input wire logic        SYS_RST,              // Reset
  input wire logic        SCL_CLK,              // Serial clock
  input wire logic        SDA_OUT,              // Drive value
  input wire logic        SDA_OE_N,             // Drive enable
  input wire logic        LOAD_OUTPUT_STROBE_N, // Load strobe
  input wire logic        RESET_PIN_N,          // Reset pin
  input wire logic [15:0] ACTIVE_OUTPUT_CODE,   // Output code
  input wire logic        GAIN_X2,              // Gain
  input wire logic        REF_DISABLE,          // Reference off
  input wire logic        POWERDOWN_SEL_HI,     // Power-down high
  input wire logic        POWERDOWN_SEL_LO      // Power-down low
);
  logic [8:0] low_reg;  // Cycles of device low drive
  wire  [3:0] ctl = {POWERDOWN_SEL_HI, POWERDOWN_SEL_LO, REF_DISABLE, GAIN_X2};
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // Length of the current low drive; a read holds at most nine bit times
  always_ff @(posedge CLK or posedge SYS_RST)
    if (SYS_RST)
      low_reg <= 9'h000;
    else
      low_reg <= SDA_OE_N ? 9'h000 : low_reg + 9'h001;
  property p_drive_zero; SDA_OUT == 1'b0; endproperty
  a_drive_zero: assert property (p_drive_zero) else $error("drive value not low");
  property p_oe_scl_low; $changed(SDA_OE_N) |-> !SCL_CLK; endproperty
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("data moved, clock high");
  property p_low_run; low_reg <= 9'h12C; endproperty
  a_low_run: assert property (p_low_run) else $error("data held low too long");
  property p_pin_def;
    (!RESET_PIN_N)[*5] |=> ACTIVE_OUTPUT_CODE == 16'h0000 && ctl == 4'h0;
  endproperty
  a_pin_def: assert property (p_pin_def) else $error("reset pin left state");
  property p_pin_hold; (!RESET_PIN_N)[*5] ##1 RESET_PIN_N |=> $stable(ACTIVE_OUTPUT_CODE)[*3];
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("code moved at release");
  property p_rel_def; $fell(SYS_RST) |-> ACTIVE_OUTPUT_CODE == 16'h0000 && ctl == 4'h0;
  endproperty
  a_rel_def: assert property (p_rel_def) else $error("defaults wrong");
  property p_strobe_ctl; $fell(LOAD_OUTPUT_STROBE_N) |=> $stable(ctl)[*8]; endproperty
  a_strobe_ctl: assert property (p_strobe_ctl) else $error("strobe moved control");
  property p_ctl_pin; $changed(ctl) && !$past(RESET_PIN_N, 3) |-> ctl == 4'h0; endproperty
  a_ctl_pin: assert property (p_ctl_pin) else $error("command taken in reset");
  c_ack: cover property ($fell(SDA_OE_N));
  c_code: cover property ($changed(ACTIVE_OUTPUT_CODE) && RESET_PIN_N);
  c_ctl: cover property ($changed(ctl));
endmodule
bind dac_i2c_port dac_i2c_checker chk_i (.CLK(CLK), .SYS_RST(SYS_RST), .SCL_CLK(SCL_CLK),
  .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N), .LOAD_OUTPUT_STROBE_N(LOAD_OUTPUT_STROBE_N),
  .RESET_PIN_N(RESET_PIN_N), .ACTIVE_OUTPUT_CODE(ACTIVE_OUTPUT_CODE), .GAIN_X2(GAIN_X2),
  .REF_DISABLE(REF_DISABLE), .POWERDOWN_SEL_HI(POWERDOWN_SEL_HI),
  .POWERDOWN_SEL_LO(POWERDOWN_SEL_LO));

/* dac_i2c_host.sv */
// Partner model: two-wire bus controller
`timescale 1ns/10ps
// ****************
// Bus controller
// ****************
module dac_i2c_host
(
  output logic      scl,  // Serial clock, high when idle
  output logic      pull, // High while pulling data low
  input  wire logic sda   // Resolved data line
);
  // Idle bus: clock high, data released
  initial
  begin
    scl = 1'b1;
    pull = 1'b0;
  end
  // Start: data falls while the clock is high; offset keeps edges off the system clock
  task automatic start_cond();
    #1.3 pull = 1'b1;
    #80 scl = 1'b0;
  endtask
  // One bit: data set in the low phase, held over the high phase
  task automatic bit_xfer(input logic b, output logic s);
    #40 pull = !b;
    #40 scl = 1'b1;
    #40 s = sda;
    #40 scl = 1'b0;
  endtask
  // Byte out, MSB first, then the acknowledge slot
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_xfer(b[i], s);
    bit_xfer(1'b1, s);
    ack = !s;
  endtask
  // Byte in; the last one is answered with no acknowledge
  task automatic get_byte(input logic last, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_xfer(1'b1, s);
      v[i] = s;
    end
    bit_xfer(last, s);
  endtask
  // Stop: data low in the low phase, rises while the clock is high
  task automatic stop_cond();
    #40 pull = 1'b1;
    #40 scl = 1'b1;
    #40 pull = 1'b0;
    #80;
  endtask
endmodule

/* dac_i2c_command_port_bench.sv */
// Testbench: command port against a register model
`timescale 1ns/10ps
`define CHK(n, g, e) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected %s expected %0h seen %0h", n, e, g); end end
// ****************
// Bench top
// ****************
module dac_i2c_command_port_bench;
  logic        clk, sys_rst, a0, strobe_n, pin_rst_n, host_pull, scl, sda_out, sda_oe_n;
  logic        gain_x2, ref_dis, pd_hi, pd_lo;
  logic [15:0] code, stg, act;
  logic [3:0]  ctl;
  logic [6:0]  dev;
  int          n_mismatch = 0;
  int          comparisons = 0;
  integer      seed = 32'h5b24;
  wire         sda = (sda_oe_n | sda_out) & !host_pull; // Pull-up unless pulled low
  always #2.5 clk = !clk;
  dac_i2c_port DUT (.CLK(clk), .SYS_RST(sys_rst), .SCL_CLK(scl), .SDA_IN(sda),
    .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .ADDRESS_SELECT_PIN(a0),
    .LOAD_OUTPUT_STROBE_N(strobe_n), .RESET_PIN_N(pin_rst_n), .ACTIVE_OUTPUT_CODE(code),
    .GAIN_X2(gain_x2), .REF_DISABLE(ref_dis), .POWERDOWN_SEL_HI(pd_hi), .POWERDOWN_SEL_LO(pd_lo));
  dac_i2c_host host (.scl(scl), .pull(host_pull), .sda(sda));
  // Register model updated per command
  task automatic apply(input logic [3:0] op, input logic [15:0] d);
    case (op)
      4'h1: stg = d;
      4'h2: act = stg;
      4'h3: {act, stg} = {d, d};
      4'h4: {act, stg, ctl} = d[15] ? 36'h0 : {act, stg, d[14:11]};
      default: ;
    endcase
  endtask
  // Outputs against the model
  task automatic check_out();
    `CHK("code", code, act)
    `CHK("control", {pd_hi, pd_lo, ref_dis, gain_x2}, ctl)
  endtask
  // Write transfer: address, command, high and low data bytes, stop
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [15:0] d,
                    output logic ok);
    logic k1, k2, k3;
    host.start_cond();
    host.put_byte({a, 1'b0}, ok);
    if (ok)
    begin
      host.put_byte(c, k1);
      host.put_byte(d[15:8], k2);
      host.put_byte(d[7:0], k3);
      ok = k1 & k2 & k3;
    end
    host.stop_cond();
    repeat (12) @(posedge clk);
  endtask
  // Read transfer: two bytes, the last without acknowledge
  task automatic rd(output logic [15:0] v);
    logic k;
    host.start_cond();
    host.put_byte({dev, 1'b1}, k);
    `CHK("read address ack", k, 1'b1)
    host.get_byte(1'b0, v[15:8]);
    host.get_byte(1'b1, v[7:0]);
    host.stop_cond();
  endtask
  // Counts and verdict
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog against a hung bus
  initial
  begin
    #450us;
    n_mismatch++;
    complete_run();
  end
  // Main sequence
  initial
  begin
    logic ok;
    logic [15:0] d, v;
    {clk, sys_rst, a0, strobe_n, pin_rst_n} = 5'h0F;
    {stg, act, ctl} = 36'h0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    check_out();
    for (int s = 0; s < 2; s++)
    begin
      a0 <= s[0];
      dev = {dac_i2c_pkg::ADDR_FIXED, s[0], 1'b0};
      @(posedge clk);
      wr({dac_i2c_pkg::ADDR_FIXED, !s[0], 1'b0}, 8'h30, 16'hFFFF, ok);
      `CHK("other address ack", ok, 1'b0)
      wr(dev | 7'h01, 8'h30, 16'hFFFF, ok);
      `CHK("odd address ack", ok, 1'b0)
      wr(7'h00, 8'h30, 16'hFFFF, ok);
      `CHK("general call ack", ok, 1'b0)
      d = $random(seed);
      wr(dev, 8'h30, d, ok);
      apply(4'h3, d);
      `CHK("write ack", ok, 1'b1)
      check_out();
    end
    for (int op = 0; op < 16; op++)
    begin
      d = $random(seed);
      wr(dev, {op[3:0], d[3:0]}, d, ok);
      apply(op[3:0], d);
      check_out();
      rd(v);
      `CHK("readback", v, stg)
    end
    d = $random(seed);
    fork
      wr(dev, 8'h10, d, ok);
      begin
        repeat (400) @(posedge clk);
        strobe_n <= 1'b0;
        repeat (4) @(posedge clk);
        strobe_n <= 1'b1;
      end
    join
    apply(4'h1, d);
    check_out();
    strobe_n <= 1'b0;
    repeat (8) @(posedge clk);
    strobe_n <= 1'b1;
    act = stg;
    check_out();
    for (int p = 0; p < 4; p++)
    begin
      d = {1'b0, p[1:0], p[0], p[1], 11'h000}; // reference off in some power-down modes
      wr(dev, 8'h40, d, ok);
      apply(4'h4, d);
      d = $random(seed);
      wr(dev, 8'h30, d, ok);
      apply(4'h3, d);
      check_out();
    end
    wr(dev, 8'h40, 16'h8000, ok);
    apply(4'h4, 16'h8000);
    check_out();
    d = $random(seed);
    wr(dev, 8'h30, d, ok);
    apply(4'h3, d);
    wr(dev, 8'h40, 16'h1800, ok);
    apply(4'h4, 16'h1800);
    check_out();
    pin_rst_n <= 1'b0;
    wr(dev, 8'h30, $random(seed), ok);
    {act, stg, ctl} = 36'h0;
    check_out();
    pin_rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    check_out();
    complete_run();
  end
endmodule
